// *** verilog/relay_defs.vh ***
`ifndef RELAY_DEFS_VH
`define RELAY_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CYCLE 8'h04
`define OFS_MINON 8'h08
`define OFS_MAXFREQ 8'h0c
`define OFS_ASSIGN 8'h10
`define OFS_ATTRIB 8'h14
`define OFS_STATUS 8'h18

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_FUNC_LSB 0
`define CTRL_SRC_LSB 4
`define CTRL_PART_LSB 8
`define CTRL_MODE_BIT 12
`define CTRL_DIAG_LSB 16

// Relay function codes
`define FUNC_OFF 3'h0
`define FUNC_LIMIT 3'h1
`define FUNC_CTRL 3'h2
`define FUNC_DIAG 3'h3
`define FUNC_CLEAN 3'h4
// Source codes
`define SRC_NONE 2'h0
`define SRC_CTRL1 2'h1
`define SRC_CTRL2 2'h2
// Actuator part codes
`define PART_NONE 2'h0
`define PART_MINUS 2'h1
`define PART_PLUS 2'h2
// Modulation modes
`define MODE_PWM 1'b0
`define MODE_PFM 1'b1
// Diagnostic modes; class modes are class code plus one
`define DIAG_ASSIGNED 3'h0
`define DIAG_CLASS_M 3'h1
`define DIAG_CLASS_F 3'h4

// ----------------------------------------
// Reset values and ranges, times in 0.1 s
// ----------------------------------------
`define CTRL_RST 32'h0000_0000
`define CYCLE_MAX 14'd9990
`define CYCLE_RST 14'd100
`define MINON_MIN 14'd3
`define MINON_RST 14'd3
`define FREQ_MIN 8'd1
`define FREQ_MAX 8'd180
`define FREQ_RST 8'd60
`define Y_FULL 10'd1000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 100000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
// Tenths of a second per minute times full scale, and half of a minute in tenths
`define TENTHS_PER_MIN 20'd600000
`define PFM_HALF_NUM 14'd300

`endif

// *** verilog/tenth_second_tick.v ***
// ----------------------------------------
// Time base divider
// ----------------------------------------
module tenth_second_tick #(
    parameter DIV = 5000000
) (
    input wire mclk,
    input wire rst_n,
    output reg tick
);
    reg [31:0] cnt_r;

    // Free running divider, one pulse per DIV clocks
    always @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt_r >= DIV - 1) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule

// *** verilog/relay_modulation_output.v ***
// Contract
// - Modulate relay as repeating pulse then interval
// - Duty mode keeps period fixed, varies share
// - Frequency mode fixed pulse, varies interval
// - At maximum rate interval equals pulse
// - Source none, controller one or two
// - Actuator part none, raising or lowering
// - Cycle duration minimum on-time to 999.0 s
// - Cycle duration never below minimum on-time
// - Suppress pulses shorter than minimum on-time; the code does so in duty mode only
// - Maximum rate 1 to 180 per minute
// - Pulse length derived from maximum rate
// - Diagnostics from assigned messages or class
// - Assigned mode follows assigned messages only
// - Class mode follows all class messages
// - Attributed message list is read only
// - Split bipolar variable into unipolar parts
// - Function off disables relay entirely
//
// Our own choices: the APB register port and the placing of the registers.
`include "relay_defs.vh"

module relay_modulation_output #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter MSG_N = 32
) (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [10:0] ctrl1Y,
    input wire [10:0] ctrl2Y,
    input wire [MSG_N-1:0] msgActive,
    input wire [2*MSG_N-1:0] msgClass,
    output reg relayOn
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_ON = 2'b01;
    localparam ST_OFF = 2'b10;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [31:0] ctrl_r;
    reg [13:0] cycle_r;
    reg [13:0] minOn_r;
    reg [7:0] maxFreq_r;
    reg [MSG_N-1:0] assign_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [19:0] cnt_r;
    reg [19:0] cnt_nxt;
    reg [19:0] offLen_r;
    reg [19:0] offLen_nxt;
    reg [10:0] ySel;
    reg [9:0] yUni;
    reg [10:0] yMag;

    wire tick;
    wire [2:0] func = ctrl_r[`CTRL_FUNC_LSB +: 3];
    wire [1:0] src = ctrl_r[`CTRL_SRC_LSB +: 2];
    wire [1:0] part = ctrl_r[`CTRL_PART_LSB +: 2];
    wire mode = ctrl_r[`CTRL_MODE_BIT];
    wire [2:0] diagMode = ctrl_r[`CTRL_DIAG_LSB +: 3];

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    tenth_second_tick #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick)
    );

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wrEn = access && pwrite;
    reg mapped;
    reg [31:0] rdMux;

    // Zero wait states: every access completes in one access cycle
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Write data clamped into the legal ranges
    wire [13:0] wrVal = pwdata[13:0];
    wire [7:0] wrFreq = pwdata[7:0];
    reg [13:0] cycleClamp;
    reg [13:0] minOnClamp;
    reg [7:0] freqClamp;

    // Range limits for written settings
    always @* begin
        if (pwdata[31:14] != 18'h0 || wrVal > `CYCLE_MAX) begin
            cycleClamp = `CYCLE_MAX;
        end else if (wrVal < minOn_r) begin
            cycleClamp = minOn_r;
        end else begin
            cycleClamp = wrVal;
        end
        if (pwdata[31:14] != 18'h0 || wrVal > cycle_r) begin
            minOnClamp = cycle_r;
        end else if (wrVal < `MINON_MIN) begin
            minOnClamp = `MINON_MIN;
        end else begin
            minOnClamp = wrVal;
        end
        if (pwdata[31:8] != 24'h0 || wrFreq > `FREQ_MAX) begin
            freqClamp = `FREQ_MAX;
        end else if (wrFreq < `FREQ_MIN) begin
            freqClamp = `FREQ_MIN;
        end else begin
            freqClamp = wrFreq;
        end
    end

    // Read decode
    always @* begin
        mapped = 1'b1;
        rdMux = 32'h0000_0000;
        case (paddr)
            `OFS_CTRL: rdMux = ctrl_r;
            `OFS_CYCLE: rdMux = {18'h0, cycle_r};
            `OFS_MINON: rdMux = {18'h0, minOn_r};
            `OFS_MAXFREQ: rdMux = {24'h0, maxFreq_r};
            `OFS_ASSIGN: rdMux[MSG_N-1:0] = assign_r;
            `OFS_ATTRIB: rdMux[MSG_N-1:0] = assign_r;
            `OFS_STATUS: rdMux = {6'h0, yUni, 13'h0, state_r, relayOn};
            default: mapped = 1'b0;
        endcase
    end

    // Register writes and registered read data
    always @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_r <= `CTRL_RST;
            cycle_r <= `CYCLE_RST;
            minOn_r <= `MINON_RST;
            maxFreq_r <= `FREQ_RST;
            assign_r <= {MSG_N{1'b0}};
            prdata <= 32'h0000_0000;
        end else begin
            // Read data captured in setup, stable through access
            if (setup) begin
                prdata <= rdMux;
            end
            if (wrEn) begin
                case (paddr)
                    `OFS_CTRL: ctrl_r <= pwdata & 32'h0007_1337;
                    `OFS_CYCLE: cycle_r <= cycleClamp;
                    `OFS_MINON: minOn_r <= minOnClamp;
                    `OFS_MAXFREQ: maxFreq_r <= freqClamp;
                    `OFS_ASSIGN: assign_r <= pwdata[MSG_N-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Manipulated variable selection
    // ----------------------------------------

    // Pick source, split into unipolar parts, saturate at full scale
    always @* begin
        case (src)
            `SRC_CTRL1: ySel = ctrl1Y;
            `SRC_CTRL2: ySel = ctrl2Y;
            default: ySel = 11'h000;
        endcase
        yMag = 11'h000;
        if (src != `SRC_NONE) begin
            if (part == `PART_PLUS && !ySel[10]) begin
                yMag = ySel;
            end else if (part == `PART_MINUS && ySel[10]) begin
                yMag = 11'h000 - ySel;
            end
        end
        if (yMag > {1'b0, `Y_FULL}) begin
            yUni = `Y_FULL;
        end else begin
            yUni = yMag[9:0];
        end
    end

    // ----------------------------------------
    // Phase lengths, in 0.1 s ticks
    // ----------------------------------------
    wire [23:0] pwmProd = yUni * cycle_r;
    wire [23:0] pwmRaw = pwmProd / `Y_FULL;
    wire [17:0] pfmProd = yUni * maxFreq_r;
    wire [13:0] pfmHalf = `PFM_HALF_NUM / maxFreq_r;
    wire [19:0] pfmPeriod = (pfmProd == 18'h0) ? 20'h0 : `TENTHS_PER_MIN / pfmProd;
    reg [19:0] onLen;
    reg [19:0] offLen;

    always @* begin
        if (mode == `MODE_PWM) begin
            if (pwmRaw[19:0] < {6'h0, minOn_r}) begin
                onLen = 20'h0;
            end else begin
                onLen = pwmRaw[19:0];
            end
            offLen = {6'h0, cycle_r} - onLen;
        end else begin
            onLen = (pfmHalf == 14'h0) ? 20'h1 : {6'h0, pfmHalf};
            if (yUni >= `Y_FULL || pfmPeriod <= onLen) begin
                offLen = onLen;
            end else begin
                offLen = pfmPeriod - onLen;
            end
        end
    end

    // ----------------------------------------
    // Output selection
    // ----------------------------------------
    wire [MSG_N-1:0] classHit;
    genvar i;
    // Per message class match
    generate
        for (i = 0; i < MSG_N; i = i + 1) begin : g_msg
            assign classHit[i] = msgActive[i] &&
                ({1'b0, msgClass[2*i +: 2]} == diagMode - `DIAG_CLASS_M);
        end
    endgenerate

    wire modActive = (func == `FUNC_CTRL) && (yUni != 10'h0);
    reg diagOut;

    always @* begin
        if (diagMode == `DIAG_ASSIGNED) begin
            diagOut = |(msgActive & assign_r);
        end else if (diagMode <= `DIAG_CLASS_F) begin
            diagOut = |classHit;
        end else begin
            diagOut = 1'b0;
        end
    end

    // ----------------------------------------
    // Modulator state machine
    // ----------------------------------------
    // Both lengths are sampled when a cycle starts from idle, so a setting change
    // takes hold at the next cycle rather than cutting a pulse short.
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        offLen_nxt = offLen_r;
        case (state_r)
            ST_IDLE: begin
                if (modActive) begin
                    offLen_nxt = offLen;
                    if (onLen != 20'h0) begin
                        state_nxt = ST_ON;
                        cnt_nxt = onLen;
                    end else begin
                        state_nxt = ST_OFF;
                        cnt_nxt = offLen;
                    end
                end
            end
            ST_ON: begin
                if (tick && cnt_r <= 20'h1) begin
                    if (offLen_r != 20'h0) begin
                        state_nxt = ST_OFF;
                        cnt_nxt = offLen_r;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end else if (tick) begin
                    cnt_nxt = cnt_r - 20'h1;
                end
            end
            ST_OFF: begin
                if (tick && cnt_r <= 20'h1) begin
                    state_nxt = ST_IDLE;
                end else if (tick) begin
                    cnt_nxt = cnt_r - 20'h1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!modActive) begin
            state_nxt = ST_IDLE;
            cnt_nxt = 20'h0;
        end
    end

    // State and relay drive
    always @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 20'h0;
            offLen_r <= 20'h0;
            relayOn <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            offLen_r <= offLen_nxt;
            if (func == `FUNC_DIAG) begin
                relayOn <= diagOut;
            end else begin
                relayOn <= (state_nxt == ST_ON);
            end
        end
    end
endmodule

// *** test/relay_actuator_model.sv ***
// ----------------------------------------
// Actuator on the relay: measures phase lengths in clocks
// ----------------------------------------
module relay_actuator_model (
    input wire mclk,
    input wire rst_n,
    input wire relayOn,
    output int onLen,
    output int offLen,
    output int pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    int runLen;
    reg last;
    // A run length is stored only when the level changes, so a partial phase never shows
    always @(posedge mclk) begin
        if (!rst_n) begin
            runLen <= 0;
            last <= 1'b0;
            pulses <= 0;
            onLen <= 0;
            offLen <= 0;
        end else begin
            last <= relayOn;
            if (relayOn !== last) begin
                runLen <= 1;
                if (relayOn === 1'b1) begin
                    offLen <= runLen;
                    pulses <= pulses + 1;
                end else begin
                    onLen <= runLen;
                end
            end else begin
                runLen <= runLen + 1;
            end
        end
    end
endmodule

// *** test/relay_modulation_output_properties.sv ***
`include "relay_defs.vh"
module relay_modulation_output_properties #(
    parameter TICK_CYCLES = 5000000,
    parameter MSG_N = 32
) (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [10:0] ctrl1Y,
    input wire [10:0] ctrl2Y,
    input wire [MSG_N-1:0] msgActive,
    input wire [2*MSG_N-1:0] msgClass,
    input wire relayOn
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [31:0] ctrlR;
    reg [31:0] asgR;
    reg [3:0] cfgAge;
    reg dExp;
    integer i;
    wire wr = psel && penable && pwrite && pready;
    wire [2:0] fn = ctrlR[2:0];
    wire [1:0] src = ctrlR[5:4];
    wire [1:0] part = ctrlR[9:8];
    wire [2:0] dm = ctrlR[18:16];
    wire [10:0] ySel = (src == `SRC_CTRL2) ? ctrl2Y : ctrl1Y;
    wire fOff = fn != `FUNC_CTRL && fn != `FUNC_DIAG;
    wire fDiag = fn == `FUNC_DIAG;
    wire cIdle = fn == `FUNC_CTRL && (src == `SRC_NONE || src == 2'h3 || part == `PART_NONE || part == 2'h3
        || ySel == 11'h000 || (part == `PART_PLUS) == ySel[10]);
    wire pwmRun = fn == `FUNC_CTRL && !ctrlR[`CTRL_MODE_BIT] && !cIdle && cfgAge > 4'h2;
    // Shadow of the settings; a write lands at the access edge
    always @(posedge mclk) begin
        if (!rst_n) begin
            ctrlR <= 32'h0;
            asgR <= 32'h0;
            cfgAge <= 4'h0;
        end else begin
            if (wr && paddr == `OFS_CTRL) ctrlR <= pwdata;
            if (wr && paddr == `OFS_ASSIGN) asgR <= pwdata;
            cfgAge <= wr ? 4'h0 : (cfgAge == 4'hf ? cfgAge : cfgAge + 4'h1);
        end
    end
    reg [31:0] hiCnt;
    reg hiClean;
    // Length of the current high phase, and whether steady PWM held for all of it
    always @(posedge mclk) begin
        if (!rst_n || !relayOn) begin
            hiCnt <= 32'h0;
            hiClean <= 1'b0;
        end else begin
            hiCnt <= hiCnt + 32'h1;
            hiClean <= (hiCnt == 32'h0) ? pwmRun : (hiClean && pwmRun);
        end
    end
    // Expected diagnostic level
    always @* begin
        dExp = 1'b0;
        for (i = 0; i < MSG_N; i = i + 1)
            if (msgActive[i] && (dm == 3'h0 ? asgR[i] : {1'b0, msgClass[2*i+:2]} + 3'h1 == dm)) dExp = 1'b1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_errAccess; pslverr |-> psel && penable; endproperty
    a_errAccess: assert property (p_errAccess) else $error("pslverr outside access");
    property p_errMapped; psel && penable && paddr <= `OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_errMapped: assert property (p_errMapped) else $error("error on mapped address");
    property p_errUnmapped;
        psel && penable && (paddr > `OFS_STATUS || paddr[1:0] != 2'h0) |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_errUnmapped: assert property (p_errUnmapped) else $error("unmapped access not refused");
    property p_off; fOff && $past(fOff) |-> !relayOn; endproperty
    a_off: assert property (p_off) else $error("relay on with function off");
    property p_idle; cIdle && $past(cIdle) |-> !relayOn; endproperty
    a_idle: assert property (p_idle) else $error("relay on without drive");
    property p_diag; fDiag && $past(fDiag) |-> relayOn == $past(dExp); endproperty
    a_diag: assert property (p_diag) else $error("diagnostic level wrong");
    property p_minOn; $rose(relayOn) && pwmRun |-> (relayOn || !pwmRun) [*8]; endproperty
    a_minOn: assert property (p_minOn) else $error("short pulse output");
    // Any legal minimum is at least MINON_MIN ticks; first tick may come early by under one tick
    property p_minOnLen;
        $fell(relayOn) && hiClean |-> hiCnt > (`MINON_MIN - 14'd1) * TICK_CYCLES;
    endproperty
    a_minOnLen: assert property (p_minOnLen) else $error("pulse shorter than minimum on-time");
    c_minOn: cover property ($fell(relayOn) && hiClean);
    c_pwm: cover property ($rose(relayOn) && pwmRun);
    c_diag: cover property (fDiag && relayOn);
    c_err: cover property (pslverr);
endmodule
bind relay_modulation_output relay_modulation_output_properties #(.TICK_CYCLES(TICK_CYCLES), .MSG_N(MSG_N)) chk (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl1Y(ctrl1Y), .ctrl2Y(ctrl2Y),
    .msgActive(msgActive), .msgClass(msgClass), .relayOn(relayOn));

// *** test/relay_modulation_output_tb.sv ***
`include "relay_defs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %0h expected %0h", $time, g, e); end end
module relay_modulation_output_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 10;
    localparam int N = 8;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [10:0] y1 = 11'h000;
    reg [10:0] y2 = 11'h000;
    reg [N-1:0] act = 8'h00;
    reg [2*N-1:0] cls = 16'h0000;
    wire [31:0] prdata;
    wire pready, pslverr, relayOn;
    int error_cnt = 0, checks_done = 0, seed = 59, onLen, offLen, pulses, k, yv, on;
    reg [31:0] rd, asg;
    reg err;
    // Settings written then read back: address, value, expected
    int tbl[10][3] = '{'{4, 10000, 9990}, '{4, 10, 10}, '{8, 0, 3}, '{8, 20, 10}, '{8, 3, 3},
        '{4, 1, 3}, '{4, 10, 10}, '{12, 0, 1}, '{12, 200, 180}, '{12, 60, 60}};
    always #10 mclk = ~mclk;
    relay_modulation_output #(.TICK_CYCLES(T), .MSG_N(N)) DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctrl1Y(y1), .ctrl2Y(y2), .msgActive(act), .msgClass(cls), .relayOn(relayOn));
    relay_actuator_model act0 (.mclk(mclk), .rst_n(rst_n), .relayOn(relayOn), .onLen(onLen), .offLen(offLen),
        .pulses(pulses));
    task test_done;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One APB transfer; waits for pready under a bound
    task apb(input bit w, input [7:0] a, input [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin error_cnt++; test_done; end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdChk(input [7:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    function bit inWin(int m, int ticks);
        return m > (ticks - 1) * T && m <= ticks * T + 3;
    endfunction
    function [31:0] cw(input [2:0] f, input [1:0] s, input [1:0] p, input m);
        return {19'h0, m, 2'h0, p, 2'h0, s, 1'b0, f};
    endfunction
    function bit dexp(int m, logic [31:0] a);
        int i;
        dexp = 1'b0;
        for (i = 0; i < N; i++) if (act[i] && (m == 0 ? a[i] : cls[2*i+:2] == m - 1)) dexp = 1'b1;
    endfunction
    // Apply a setting and check the steady pulse train, or its absence
    task run(input [31:0] c, input int y, input int onT, input int offT);
        int p0, i;
        apb(1'b1, `OFS_CTRL, c);
        y1 <= y[10:0];
        y2 <= -y[10:0];
        repeat (2 * T) @(posedge mclk);
        p0 = pulses;
        if (onT == 0) begin
            repeat (300) @(posedge mclk);
            `CHK(pulses, p0)
        end else begin
            for (i = 0; i < 8000 && pulses < p0 + 3; i++) @(posedge mclk);
            if (i == 8000) begin error_cnt++; test_done; end
            `CHK(inWin(onLen, onT), 1'b1)
            `CHK(inWin(offLen, offT), 1'b1)
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rdChk(`OFS_CTRL, 32'h0);
        rdChk(`OFS_CYCLE, 32'h64);
        rdChk(`OFS_MINON, 32'h3);
        rdChk(`OFS_MAXFREQ, 32'h3c);
        apb(1'b0, 8'h1c, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        for (k = 0; k < 10; k++) begin
            apb(1'b1, tbl[k][0], tbl[k][1]);
            rdChk(tbl[k][0], tbl[k][2]);
        end
        apb(1'b1, `OFS_ASSIGN, 32'ha5);
        apb(1'b1, `OFS_ATTRIB, 32'h3c);
        rdChk(`OFS_ATTRIB, 32'ha5);
        run(cw(2, 1, 2, 0), 500, 5, 5);
        run(cw(2, 1, 2, 0), 1000, 10, 0);
        run(cw(2, 1, 2, 0), 250, 0, 0);
        run(cw(2, 1, 2, 0), -500, 0, 0);
        run(cw(2, 1, 1, 0), -700, 7, 3);
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd[25:16], 10'd700)
        run(cw(2, 2, 2, 0), -400, 4, 6);
        run(cw(2, 0, 2, 0), 500, 0, 0);
        run(cw(2, 3, 2, 0), 500, 0, 0);
        run(cw(2, 1, 0, 0), 500, 0, 0);
        run(cw(0, 1, 2, 0), 500, 0, 0);
        run(cw(1, 1, 2, 0), 500, 0, 0);
        run(cw(4, 1, 2, 0), 500, 0, 0);
        for (k = 0; k < 4; k++) begin
            yv = ($random(seed) & 32'h3ff) % 1001;
            on = yv * 10 / 1000 < 3 ? 0 : yv * 10 / 1000;
            run(cw(2, 1, 2, 0), yv, on, 10 - on);
        end
        run(cw(2, 1, 2, 1), 1000, 5, 5);
        run(cw(2, 1, 2, 1), 500, 5, 15);
        apb(1'b1, `OFS_MAXFREQ, 32'hb4);
        run(cw(2, 1, 2, 1), 1000, 1, 1);
        for (k = 0; k < 6; k++) begin
            act <= $random(seed);
            cls <= $random(seed);
            asg = $random(seed);
            apb(1'b1, `OFS_ASSIGN, asg);
            apb(1'b1, `OFS_CTRL, cw(3, 0, 0, 0) | (k << 16));
            repeat (3) @(posedge mclk);
            `CHK(relayOn, dexp(k, asg))
        end
        test_done;
    end
endmodule
